// file: shared/mmd_defines.svh
// Address map, field positions and timing counts of the memory map decoder
`ifndef MMD_DEFINES_SVH
`define MMD_DEFINES_SVH

// Whole space is one flat 32-bit map
`define MMD_ADDR_W        32
`define MMD_OFS_W         27

// Control register blocks near the top of the space
`define MMD_CMMR_BASE     32'hFFE0_0000
`define MMD_CMMR_MASK     32'hFFE0_0000
`define MMD_SMMR_BASE     32'hFFC0_0000
`define MMD_SMMR_MASK     32'hFFE0_0000

// Per-core level-1 windows, 4M each
`define MMD_L1_C0_BASE    32'hFF80_0000
`define MMD_L1_C1_BASE    32'hFF40_0000
`define MMD_L1_MASK       32'hFFC0_0000
`define MMD_L1_SEL_HI     21
`define MMD_L1_SEL_LO     20
`define MMD_L1_SEL_DATA   2'h0
`define MMD_L1_SEL_INSTR  2'h2
`define MMD_L1_SEL_SCR    2'h3

// Level-1 bank geometry: 16K banks of four 4K sub-banks
`define MMD_BANK_HI       15
`define MMD_BANK_LO       14
`define MMD_SUB_HI        13
`define MMD_SUB_LO        12
`define MMD_DATA_TOP      16
`define MMD_INSTR_TOP     15
`define MMD_SCR_TOP       12

// Shared level-2 SRAM, 128K, 64-bit port
`define MMD_L2_BASE       32'hFEB0_0000
`define MMD_L2_MASK       32'hFFFE_0000
`define MMD_L2_LANE       2

// External banks
`define MMD_ASYNC_BASE    32'h2000_0000
`define MMD_ASYNC_MASK    32'hF000_0000
`define MMD_ASYNC_SEG_HI  27
`define MMD_ASYNC_SEG_LO  26
`define MMD_SDRAM_MIN_LOG 24
`define MMD_SDRAM_BANKS   4

// Extra wait cycles of a level-2 access
`define MMD_L2_WAIT       1

`endif

// file: shared/mmd_pkg.sv
// Types shared by the memory map decoder files
package mmd_pkg;

	typedef enum logic [3:0] {
		MMD_TGT_NONE     = 4'h0,
		MMD_TGT_L1_INSTR = 4'h1,
		MMD_TGT_L1_DATA  = 4'h2,
		MMD_TGT_SCRATCH  = 4'h3,
		MMD_TGT_L2       = 4'h4,
		MMD_TGT_SDRAM    = 4'h5,
		MMD_TGT_ASYNC    = 4'h6,
		MMD_TGT_CORE_REG = 4'h7,
		MMD_TGT_SYS_REG  = 4'h8
	} mmd_target_t;

	typedef enum logic [1:0] {
		MMD_SRC_CORE0 = 2'h0,
		MMD_SRC_CORE1 = 2'h1,
		MMD_SRC_DMA1  = 2'h2,
		MMD_SRC_DMA2  = 2'h3
	} mmd_src_t;

	typedef enum logic [1:0] {
		MMD_ST_IDLE    = 2'b01,
		MMD_ST_L2_WAIT = 2'b10
	} mmd_state_t;

endpackage

// file: design/mmd_sdram_map.sv
// Contiguous decode of four programmable synchronous DRAM banks
`timescale 1ns/1ps
`include "mmd_defines.svh"

module mmd_sdram_map
	import mmd_pkg::*;
(
	input  wire logic [31:0] addr_i,
	input  wire logic [7:0]  size_code_i,
	output logic             hit_o,
	output logic [1:0]       bank_o,
	output logic [26:0]      offset_o
);

	// ========================================
	// Bank bases
	// ========================================
	logic [29:0] size_w [4];
	logic [29:0] base_w [5];

	assign base_w[0] = 30'h0000_0000;

	// Each bank starts where the previous one ends, whatever its size
	genvar g;
	generate
		for (g = 0; g < `MMD_SDRAM_BANKS; g++) begin : g_bank
			assign size_w[g] = 30'h0100_0000 << size_code_i[2*g +: 2];
			assign base_w[g+1] = base_w[g] + size_w[g];
		end
	endgenerate

	// ========================================
	// Bank select
	// ========================================
	// Top base bounds the whole region; at most 512M
	always_comb begin
		logic [29:0] rel;
		rel      = 30'h0000_0000;
		hit_o    = 1'b0;
		bank_o   = 2'h0;
		offset_o = 27'h000_0000;
		if (addr_i[31:30] == 2'h0 && addr_i[29:0] < base_w[4]) begin
			hit_o = 1'b1;
			for (int i = 0; i < `MMD_SDRAM_BANKS; i++) begin
				if (addr_i[29:0] >= base_w[i]) begin
					bank_o = 2'(i);
					rel    = addr_i[29:0] - base_w[i];
				end
			end
			offset_o = rel[26:0];
		end
	end

endmodule

// file: design/mmd_decoder.sv
// Flat address space decoder with privilege and requester checks
`timescale 1ns/1ps
`include "mmd_defines.svh"

module mmd_decoder
	import mmd_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        req_valid_i,
	input  wire logic [31:0] req_addr_i,
	input  wire logic        req_write_i,
	input  wire logic [1:0]  req_src_i,
	input  wire logic        req_super_i,
	input  wire logic        req_emu_i,
	input  wire logic [1:0]  icache_en_i,
	input  wire logic [1:0]  dcache_en_i,
	input  wire logic        sys_visible_i,
	input  wire logic [7:0]  sdram_size_i,
	output logic             req_ready_o,
	output logic             rsp_valid_o,
	output logic [3:0]       rsp_target_o,
	output logic             rsp_core_o,
	output logic [1:0]       rsp_bank_o,
	output logic [1:0]       rsp_sub_o,
	output logic [26:0]      rsp_offset_o,
	output logic             rsp_lane_o,
	output logic             rsp_write_o,
	output logic             rsp_fault_o,
	output logic [1:0]       fault_core_o,
	output logic             fault_dma_o
);

	// ========================================
	// Helpers
	// ========================================
	// Region match on the masked upper address bits
	function automatic logic in_region(input logic [31:0] a,
		input logic [31:0] base, input logic [31:0] mask);
		in_region = ((a & mask) == base);
	endfunction

	// Zero check of address bits between the sub-region top and bit 19
	function automatic logic upper_clear(input logic [31:0] a, input int top);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < `MMD_L1_SEL_LO; i++) begin
			if (i >= top && a[i]) begin
				ok = 1'b0;
			end
		end
		upper_clear = ok;
	endfunction

	// ========================================
	// Decode signals
	// ========================================
	mmd_state_t  state_reg;
	logic        is_core;
	logic        own_core;
	logic        priv;
	logic        sd_hit;
	logic [1:0]  sd_bank;
	logic [26:0] sd_ofs;
	logic [1:0]  l1_sel;
	logic        take;

	mmd_target_t tgt_next;
	logic        core_next;
	logic [1:0]  bank_next;
	logic [1:0]  sub_next;
	logic [26:0] ofs_next;
	logic        lane_next;
	logic        fault_next;

	logic        hold_write_reg;
	logic        hold_src_dma_reg;
	logic        hold_core_reg;

	// Emulation mode carries supervisor rights
	assign priv     = req_super_i | req_emu_i;
	assign is_core  = ~req_src_i[1];
	assign own_core = req_src_i[0];
	assign l1_sel   = req_addr_i[`MMD_L1_SEL_HI:`MMD_L1_SEL_LO];
	assign take     = req_valid_i & req_ready_o;

	// Programmable external DRAM banks, one continuous region
	mmd_sdram_map u_sdram_map (
		.addr_i      (req_addr_i),
		.size_code_i (sdram_size_i),
		.hit_o       (sd_hit),
		.bank_o      (sd_bank),
		.offset_o    (sd_ofs)
	);

	// ========================================
	// Address decode and access check
	// ========================================
	// Register blocks win first since they sit above every memory window.
	// Anything left unmatched is reserved and faults.
	always_comb begin
		tgt_next   = MMD_TGT_NONE;
		core_next  = 1'b0;
		bank_next  = 2'h0;
		sub_next   = 2'h0;
		ofs_next   = 27'h000_0000;
		lane_next  = 1'b0;
		fault_next = 1'b1;
		if (in_region(req_addr_i, `MMD_CMMR_BASE, `MMD_CMMR_MASK)) begin
			// Each core sees its own copy; DMA sees reserved space
			tgt_next  = MMD_TGT_CORE_REG;
			core_next = own_core;
			ofs_next  = {6'h00, req_addr_i[20:0]};
			fault_next = ~(is_core & priv);
		end else if (in_region(req_addr_i, `MMD_SMMR_BASE, `MMD_SMMR_MASK)) begin
			tgt_next  = MMD_TGT_SYS_REG;
			ofs_next  = {6'h00, req_addr_i[20:0]};
			if (is_core) begin
				fault_next = ~priv;
			end else begin
				fault_next = ~sys_visible_i;
			end
		end else if (in_region(req_addr_i, `MMD_L1_C0_BASE, `MMD_L1_MASK) ||
			in_region(req_addr_i, `MMD_L1_C1_BASE, `MMD_L1_MASK)) begin
			core_next = ~req_addr_i[23];
			bank_next = req_addr_i[`MMD_BANK_HI:`MMD_BANK_LO];
			sub_next  = req_addr_i[`MMD_SUB_HI:`MMD_SUB_LO];
			ofs_next  = {11'h000, req_addr_i[15:0]};
			case (l1_sel)
				`MMD_L1_SEL_DATA: begin
					tgt_next = MMD_TGT_L1_DATA;
					// Banks 0 and 1 vanish while they serve as cache
					fault_next = ~upper_clear(req_addr_i, `MMD_DATA_TOP) |
						(~req_addr_i[`MMD_BANK_HI] & dcache_en_i[core_next]);
					sub_next = req_addr_i[`MMD_SUB_HI:`MMD_SUB_LO];
				end
				`MMD_L1_SEL_INSTR: begin
					tgt_next  = MMD_TGT_L1_INSTR;
					bank_next = {1'b0, req_addr_i[`MMD_BANK_LO]};
					// Bank 1 is the 4-way cache unless set as SRAM
					fault_next = ~upper_clear(req_addr_i, `MMD_INSTR_TOP) |
						(req_addr_i[`MMD_BANK_LO] & icache_en_i[core_next]);
				end
				`MMD_L1_SEL_SCR: begin
					tgt_next  = MMD_TGT_SCRATCH;
					bank_next = 2'h0;
					sub_next  = 2'h0;
					ofs_next  = {15'h0000, req_addr_i[11:0]};
					// Data-only SRAM, closed to DMA
					fault_next = ~upper_clear(req_addr_i, `MMD_SCR_TOP) |
						~is_core;
				end
				default: begin
					tgt_next   = MMD_TGT_NONE;
					fault_next = 1'b1;
				end
			endcase
		end else if (in_region(req_addr_i, `MMD_L2_BASE, `MMD_L2_MASK)) begin
			// One 64-bit port; lane picks the 32-bit half
			tgt_next   = MMD_TGT_L2;
			ofs_next   = {13'h0000, req_addr_i[16:3]};
			lane_next  = req_addr_i[`MMD_L2_LANE];
			fault_next = 1'b0;
		end else if (in_region(req_addr_i, `MMD_ASYNC_BASE, `MMD_ASYNC_MASK)) begin
			// Fixed 64M segment per bank, holes if a device is smaller
			tgt_next   = MMD_TGT_ASYNC;
			bank_next  = req_addr_i[`MMD_ASYNC_SEG_HI:`MMD_ASYNC_SEG_LO];
			ofs_next   = {1'b0, req_addr_i[25:0]};
			fault_next = 1'b0;
		end else if (sd_hit) begin
			tgt_next   = MMD_TGT_SDRAM;
			bank_next  = sd_bank;
			ofs_next   = sd_ofs;
			fault_next = 1'b0;
		end
	end

	// ========================================
	// Access pacing
	// ========================================
	// Level-2 runs at half the core rate: a taken level-2 access closes
	// the request port for one cycle and answers one cycle later.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg   <= MMD_ST_IDLE;
			req_ready_o <= 1'b1;
		end else begin
			case (state_reg)
				MMD_ST_IDLE: begin
					if (take && tgt_next == MMD_TGT_L2 && !fault_next) begin
						state_reg   <= MMD_ST_L2_WAIT;
						req_ready_o <= 1'b0;
					end
				end
				MMD_ST_L2_WAIT: begin
					state_reg   <= MMD_ST_IDLE;
					req_ready_o <= 1'b1;
				end
				default: begin
					state_reg   <= MMD_ST_IDLE;
					req_ready_o <= 1'b1;
				end
			endcase
		end
	end

	// ========================================
	// Routing result
	// ========================================
	// Captured on every taken request; level-2 result is held through the wait
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rsp_target_o     <= 4'h0;
			rsp_core_o       <= 1'b0;
			rsp_bank_o       <= 2'h0;
			rsp_sub_o        <= 2'h0;
			rsp_offset_o     <= 27'h000_0000;
			rsp_lane_o       <= 1'b0;
			rsp_fault_o      <= 1'b0;
			hold_write_reg   <= 1'b0;
			hold_src_dma_reg <= 1'b0;
			hold_core_reg    <= 1'b0;
		end else if (take) begin
			// A faulted access names no target
			rsp_target_o     <= fault_next ? MMD_TGT_NONE : tgt_next;
			rsp_core_o       <= core_next;
			rsp_bank_o       <= bank_next;
			rsp_sub_o        <= sub_next;
			rsp_offset_o     <= ofs_next;
			rsp_lane_o       <= lane_next;
			rsp_fault_o      <= fault_next;
			hold_write_reg   <= req_write_i;
			hold_src_dma_reg <= req_src_i[1];
			hold_core_reg    <= own_core;
		end
	end

	// ========================================
	// Completion strobe
	// ========================================
	logic rsp_fire;
	assign rsp_fire = (state_reg == MMD_ST_IDLE) ? (take && !(tgt_next == MMD_TGT_L2 &&
		!fault_next)) : (state_reg == MMD_ST_L2_WAIT);

	// One-cycle answer pulse, late by one for level-2
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rsp_valid_o <= 1'b0;
		end else begin
			rsp_valid_o <= rsp_fire;
		end
	end

	// Write strobe is dropped for a faulted access so nothing is stored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rsp_write_o <= 1'b0;
		end else if (state_reg == MMD_ST_L2_WAIT) begin
			rsp_write_o <= hold_write_reg;
		end else if (take) begin
			// A taken level-2 write waits for its answer cycle to strobe
			rsp_write_o <= req_write_i & ~fault_next & rsp_fire;
		end else begin
			rsp_write_o <= 1'b0;
		end
	end

	// ========================================
	// Fault report to the requester
	// ========================================
	// Level-2 never faults, so the fault pulse rides with the first answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_core_o <= 2'b00;
			fault_dma_o  <= 1'b0;
		end else begin
			fault_core_o <= 2'b00;
			fault_dma_o  <= 1'b0;
			if (state_reg == MMD_ST_IDLE && take && fault_next) begin
				if (is_core) begin
					fault_core_o[own_core] <= 1'b1;
				end else begin
					fault_dma_o <= 1'b1;
				end
			end
		end
	end

endmodule

// file: tb/mmd_decoder_properties.sv
// Checker of the decoder's answer timing, routing and protection
`timescale 1ns/1ps
module mmd_decoder_checker (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        req_valid_i,
	input wire logic [31:0] req_addr_i,
	input wire logic [1:0]  req_src_i,
	input wire logic        req_super_i,
	input wire logic        req_emu_i,
	input wire logic        sys_visible_i,
	input wire logic        req_ready_o,
	input wire logic        rsp_valid_o,
	input wire logic [3:0]  rsp_target_o,
	input wire logic        rsp_core_o,
	input wire logic [1:0]  rsp_bank_o,
	input wire logic [26:0] rsp_offset_o,
	input wire logic        rsp_write_o,
	input wire logic        rsp_fault_o,
	input wire logic [1:0]  fault_core_o,
	input wire logic        fault_dma_o
);
	// ==========================================
	// Region hits of the request being taken
	logic take, l2, creg, sreg, scr;
	assign take = req_valid_i && req_ready_o;
	assign l2   = req_addr_i[31:17] == 15'h7F58;
	assign creg = req_addr_i[31:21] == 11'h7FF;
	assign sreg = req_addr_i[31:21] == 11'h7FE;
	assign scr  = req_addr_i[31:20] == 12'hFFB || req_addr_i[31:20] == 12'hFF7;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================
	// Properties
	property p_answer_bound;
		take |-> ##[1:2] rsp_valid_o;
	endproperty
	property p_write_pulse;
		rsp_write_o |-> rsp_valid_o && !rsp_fault_o;
	endproperty
	property p_l2_wait;
		take && l2 |=> !rsp_valid_o && !req_ready_o ##1 rsp_valid_o && rsp_target_o == 4'h4;
	endproperty
	property p_fault_shape;
		rsp_valid_o && rsp_fault_o |-> rsp_target_o == 4'h0 && !rsp_write_o;
	endproperty
	property p_scratch_dma;
		take && req_src_i[1] && scr |=> rsp_valid_o && rsp_fault_o && fault_dma_o;
	endproperty
	property p_core_user;
		take && creg && !req_src_i[1] && !req_super_i && !req_emu_i
			|=> rsp_fault_o && fault_core_o == (2'b01 << $past(req_src_i[0]));
	endproperty
	property p_core_copy;
		take && creg && !req_src_i[1] && req_super_i
			|=> rsp_target_o == 4'h7 && rsp_core_o == $past(req_src_i[0]);
	endproperty
	property p_sys_dma;
		take && sreg && req_src_i[1] |=> rsp_valid_o && rsp_fault_o == !$past(sys_visible_i);
	endproperty
	property p_async;
		take && req_addr_i[31:28] == 4'h2 |=> rsp_target_o == 4'h6
			&& rsp_bank_o == $past(req_addr_i[27:26])
			&& rsp_offset_o[25:0] == $past(req_addr_i[25:0]);
	endproperty
	property p_dma_pulse;
		fault_dma_o |-> rsp_valid_o && rsp_fault_o && fault_core_o == 2'b00;
	endproperty
	a_answer_bound: assert property (p_answer_bound) else $error("no answer in time");
	a_write_pulse: assert property (p_write_pulse) else $error("stray write strobe");
	a_l2_wait: assert property (p_l2_wait) else $error("level-2 timing wrong");
	a_fault_shape: assert property (p_fault_shape) else $error("fault completed");
	a_scratch_dma: assert property (p_scratch_dma) else $error("DMA reached scratch");
	a_core_user: assert property (p_core_user) else $error("user core reg access");
	a_core_copy: assert property (p_core_copy) else $error("wrong core reg copy");
	a_sys_dma: assert property (p_sys_dma) else $error("system block visibility");
	a_async: assert property (p_async) else $error("async segment wrong");
	a_dma_pulse: assert property (p_dma_pulse) else $error("stray DMA fault");
	c_l2: cover property (take && l2);
	c_fault: cover property (rsp_valid_o && rsp_fault_o);
	c_sys_seen: cover property (take && sreg && req_src_i[1] && sys_visible_i);
endmodule

bind mmd_decoder mmd_decoder_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.req_valid_i(req_valid_i), .req_addr_i(req_addr_i), .req_src_i(req_src_i),
	.req_super_i(req_super_i), .req_emu_i(req_emu_i), .sys_visible_i(sys_visible_i),
	.req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_target_o(rsp_target_o),
	.rsp_core_o(rsp_core_o), .rsp_bank_o(rsp_bank_o), .rsp_offset_o(rsp_offset_o),
	.rsp_write_o(rsp_write_o), .rsp_fault_o(rsp_fault_o), .fault_core_o(fault_core_o),
	.fault_dma_o(fault_dma_o));

// file: tb/mmd_requester.sv
// Requester model: a core or DMA engine issuing one access at a time
`timescale 1ns/1ps
module mmd_requester (
	input  wire logic        clk_i,
	input  wire logic        req_ready_i,
	input  wire logic        rsp_valid_i,
	output logic             req_valid_o,
	output logic [31:0]      req_addr_o,
	output logic             req_write_o,
	output logic [1:0]       req_src_o,
	output logic             req_super_o,
	output logic             req_emu_o
);
	// ==========================================
	// Idle until the first access
	initial begin
		req_valid_o = 1'b0;
		req_addr_o = 32'h0000_0000;
		req_write_o = 1'b0;
		req_src_o = 2'h0;
		req_super_o = 1'b0;
		req_emu_o = 1'b0;
	end
	// Called at a falling edge; ready only moves on rising edges, so it is safe to read here.
	// One idle falling edge first, so valid is never lowered and raised in one time step.
	task automatic issue(input logic [1:0] src, input logic [1:0] mode,
		input logic [31:0] addr, input logic wr, output int lat);
		int n;
		n = 0;
		@(negedge clk_i);
		req_src_o = src;
		req_super_o = mode[0];
		req_emu_o = mode[1];
		req_addr_o = addr;
		req_write_o = wr;
		req_valid_o = 1'b1;
		while (req_ready_i !== 1'b1 && n < 8) begin
			@(negedge clk_i);
			n++;
		end
		@(posedge clk_i);
		@(negedge clk_i);
		req_valid_o = 1'b0;
		req_addr_o = ~addr; // Released bus shows no stale address
		req_write_o = ~wr;
		lat = 1;
		while (rsp_valid_i !== 1'b1 && lat < 4) begin
			@(negedge clk_i);
			lat++;
		end
	endtask
endmodule

// file: tb/mmd_decoder_bench.sv
// Self-checking bench of the memory map decoder
`timescale 1ns/1ps
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin err_total++; \
	$display("mismatch at %0t: got %0h expected %0h", $time, act, exp); end end
module mmd_decoder_bench;
	logic clk_i, rst_i, req_valid_i, req_write_i, req_super_i, req_emu_i, sys_visible_i;
	logic [31:0] req_addr_i;
	logic [1:0]  req_src_i, icache_en_i, dcache_en_i, rsp_bank_o, rsp_sub_o, fault_core_o;
	logic [7:0]  sdram_size_i;
	logic [3:0]  rsp_target_o;
	logic [26:0] rsp_offset_o;
	logic req_ready_o, rsp_valid_o, rsp_core_o, rsp_lane_o, rsp_write_o, rsp_fault_o;
	logic fault_dma_o;
	int err_total = 0;
	int check_count = 0;
	mmd_decoder u_dut (.clk_i, .rst_i, .req_valid_i, .req_addr_i, .req_write_i, .req_src_i,
		.req_super_i, .req_emu_i, .icache_en_i, .dcache_en_i, .sys_visible_i, .sdram_size_i,
		.req_ready_o, .rsp_valid_o, .rsp_target_o, .rsp_core_o, .rsp_bank_o, .rsp_sub_o,
		.rsp_offset_o, .rsp_lane_o, .rsp_write_o, .rsp_fault_o, .fault_core_o, .fault_dma_o);
	mmd_requester u_req (.clk_i, .req_ready_i(req_ready_o), .rsp_valid_i(rsp_valid_o),
		.req_valid_o(req_valid_i), .req_addr_o(req_addr_i), .req_write_o(req_write_i),
		.req_src_o(req_src_i), .req_super_o(req_super_i), .req_emu_o(req_emu_i));
	// ==========================================
	// 20 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// ==========================================
	// One access and the comparison of its answer; off below zero skips the offset
	task automatic acc(input logic [1:0] src, input logic [1:0] mode, input logic [31:0] a,
		input logic wr, input logic [3:0] tgt, input logic [1:0] bk, input logic [1:0] sb,
		input int off);
		int lat;
		logic flt;
		flt = (tgt == 4'h0);
		u_req.issue(src, mode, a, wr, lat);
		`CHK(rsp_valid_o, 1'b1)
		`CHK(lat, (tgt == 4'h4) ? 2 : 1)
		`CHK(rsp_target_o, tgt)
		`CHK(rsp_fault_o, flt)
		`CHK(rsp_write_o, wr & ~flt)
		`CHK(fault_dma_o, flt & src[1])
		`CHK(fault_core_o, (flt & ~src[1]) ? (2'b01 << src[0]) : 2'b00)
		if (tgt inside {4'h1, 4'h2, 4'h5, 4'h6}) `CHK(rsp_bank_o, bk)
		if (tgt inside {4'h1, 4'h2}) `CHK({rsp_sub_o, rsp_core_o}, {sb, a[22]})
		if (tgt == 4'h7) `CHK(rsp_core_o, src[0])
		if (tgt == 4'h4) `CHK(rsp_lane_o, a[2])
		if (off >= 0) `CHK(rsp_offset_o, off[26:0])
	endtask
	// Single place where the run ends
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Watchdog at 5000 cycles, far beyond the 66 or so cycles the accesses need
	initial begin
		#(5000 * 50);
		err_total++;
		end_of_test();
	end
	// ==========================================
	// Main sequence; core0 data and core1 instruction banks work as cache
	initial begin
		rst_i = 1'b1;
		icache_en_i = 2'b10;
		dcache_en_i = 2'b01;
		sys_visible_i = 1'b0;
		sdram_size_i = 8'hC6; // Banks of 64M, 32M, 16M, 128M
		repeat (6) @(negedge clk_i);
		rst_i = 1'b0;
		`CHK({req_ready_o, rsp_valid_o}, 2'b10)
		acc(0, 1, 32'h2400_0010, 0, 6, 1, 0, 'h10);
		acc(2, 0, 32'h2FFF_FFFC, 1, 6, 3, 0, 'h3FF_FFFC);
		acc(1, 0, 32'h0000_0008, 1, 5, 0, 0, 8);
		acc(0, 1, 32'h0400_0000, 0, 5, 1, 0, 0);
		acc(0, 1, 32'h0600_0004, 0, 5, 2, 0, 4);
		acc(3, 0, 32'h0EFF_FFFC, 0, 5, 3, 0, 'h7FF_FFFC);
		acc(0, 1, 32'h0F00_0000, 0, 0, 0, 0, -1);
		acc(0, 0, 32'hFEB0_0004, 1, 4, 0, 0, 0);
		acc(1, 1, 32'hFEB1_FFF8, 0, 4, 0, 0, 'h3FFF);
		acc(2, 0, 32'hFEB2_0000, 0, 0, 0, 0, -1);
		acc(0, 1, 32'hFF80_0000, 0, 0, 0, 0, -1);
		acc(2, 0, 32'hFF80_4000, 0, 0, 0, 0, -1);
		acc(0, 1, 32'hFF80_B000, 1, 2, 2, 3, 'hB000);
		acc(2, 0, 32'hFF40_4000, 0, 2, 1, 0, 'h4000);
		acc(0, 0, 32'hFF60_5000, 0, 0, 0, 0, -1);
		acc(1, 1, 32'hFF60_1000, 0, 1, 0, 1, 'h1000);
		acc(3, 0, 32'hFFA0_7000, 0, 1, 1, 3, 'h7000);
		acc(0, 1, 32'hFFB0_0FFC, 0, 3, 0, 0, 'hFFC);
		acc(2, 0, 32'hFFB0_0000, 0, 0, 0, 0, -1);
		acc(1, 1, 32'hFF70_1000, 0, 0, 0, 0, -1);
		acc(1, 1, 32'hFFE0_0100, 1, 7, 0, 0, 'h100);
		acc(0, 2, 32'hFFE0_0100, 0, 7, 0, 0, 'h100);
		acc(1, 0, 32'hFFE0_0100, 0, 0, 0, 0, -1);
		acc(2, 1, 32'hFFE0_0000, 0, 0, 0, 0, -1);
		acc(0, 1, 32'hFFC0_0040, 1, 8, 0, 0, 'h40);
		acc(1, 0, 32'hFFC0_0040, 0, 0, 0, 0, -1);
		acc(3, 0, 32'hFFC0_0040, 0, 0, 0, 0, -1);
		sys_visible_i = 1'b1;
		acc(3, 0, 32'hFFC0_0040, 0, 8, 0, 0, 'h40);
		acc(0, 1, 32'h3000_0000, 0, 0, 0, 0, -1);
		end_of_test();
	end
endmodule
